// ---- design/lcd_cmd_map.svh ----
`ifndef LCD_CMD_MAP_SVH
`define LCD_CMD_MAP_SVH
`define OP_POT_MODE     8'h81
`define OP_STATIC_IND   7'h56
`define OP_DRIVE_SEL    4'hd
`define OP_NO_OP        8'he3
`define OP_TEST         4'hf
`define OP_DISP_ONOFF   7'h57
`define OP_ALL_ON       7'h52
`define OP_RESET        8'he2
`define POT_BITS        6
`define BLINK_BITS      2
`define LINES_BITS      5
`define POT_RST         6'h00
`define BLINK_RST       2'h0
`define LINES_RST       5'h00
`define DRIVE_BIT       3
`define ONOFF_BIT       0
`define HI_MSB          7
`define HI_LSB          4
`define OP7_LSB         1
`endif

// ---- design/lcd_cmd_pkg.sv ----
package lcd_cmd_pkg;
  typedef enum logic [1:0] {pwr_normal, pwr_sleep, pwr_standby} pwr_state_t;
endpackage

// ---- design/cmd_byte_if.sv ----
`timescale 1ns/10ps
interface cmd_byte_if;
  logic       valid;
  logic [7:0] data;
  modport src (output valid, output data);
  modport dst (input valid, input data);
endinterface

// ---- design/cmd_byte_capture.sv ----
`timescale 1ns/10ps
module cmd_byte_capture (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic clock_en,
  // host write strobe
  input  wire logic       write_strobe,
  input  wire logic       command_data_select,
  input  wire logic [7:0] write_data,
  // captured command byte
  cmd_byte_if.src         cmd
);
  // ==========================================
  // command byte register
  // only bytes with the select line low are commands
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd.valid <= 1'b0;
      cmd.data  <= 8'h00;
    end else if (clock_en) begin
      cmd.valid <= write_strobe && !command_data_select; // R1
      if (write_strobe && !command_data_select) begin
        cmd.data <= write_data;
      end
    end
  end
endmodule

// ---- design/lcd_cmd_tail_decoder.sv ----
// What this block does
// R1 - opcode 0x81 arms potentiometer; next command byte's low six bits stored
// R2 - 1010110x sets static indicator from bit 0; next byte sets blink field
// R3 - 1101xxxx picks frame reversal if bit 3 low, line reversal if high
// R4 - byte after drive select loads low five bits as reversal line count
// R5 - power save is display off combined with all-dots-on, no own opcode
// R6 - no-operation command changes no state except clearing test mode
// R7 - upper nibble 1111 is factory test, low nibble ignored
// R8 - segment and common outputs held at ground until display configured and on
// R9 - host issues power control within 5ms of reset release
// R10 - host without internal supply enters power save within 5ms of reset
// R11 - host issues power control within 5ms of leaving power save
// R12 - host may choose sleep or standby for initial power save
// R13 - host switches LCD supply off before removing logic supply
// R14 - host gives no reset during power-off sequence
// R15 - host repeats refresh sequence periodically
// R16 - all-on while display off enters save; standby if indicator on
// R17 - reset command in standby moves device into sleep
// R18 - test needs test-enable pin high; no-operation leaves test mode
// R19 - after two-byte opcode next command byte is parameter, whatever value
`timescale 1ns/10ps
`include "lcd_cmd_map.svh"
module lcd_cmd_tail_decoder import lcd_cmd_pkg::*; (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic                     clock_en,
  // host port
  input  wire logic                     write_strobe,
  input  wire logic                     command_data_select,
  input  wire logic [7:0]               write_data,
  input  wire logic                     factory_test_enable_pin,
  // settings
  output logic [`POT_BITS-1:0]          top_bias_level,
  output logic                          static_ind_on,
  output logic [`BLINK_BITS-1:0]        blink_state,
  output logic                          line_reversal,
  output logic [`LINES_BITS-1:0]        reversal_lines,
  // status
  output logic                          display_on,
  output logic                          all_dots_on,
  output pwr_state_t                    power_state,
  output logic                          test_mode,
  output logic                          drive_outputs_grounded
);
  typedef enum logic [1:0] {arg_none, arg_pot, arg_blink, arg_lines} arg_t;

  cmd_byte_if cmd ();
  arg_t       arg_q;
  logic       configured_q;
  logic       is_op;

  cmd_byte_capture u_capture (
    .clock               (clock),
    .rst_b               (rst_b),
    .clock_en            (clock_en),
    .write_strobe        (write_strobe),
    .command_data_select (command_data_select),
    .write_data          (write_data),
    .cmd                 (cmd)
  );

  // ==========================================
  // opcode decoders, shared by the processes below except the parameter registers
  function automatic logic match7(input logic [7:0] b, input logic [6:0] op);
    return b[`HI_MSB:`OP7_LSB] == op;
  endfunction

  function automatic logic match_hi(input logic [7:0] b, input logic [3:0] op);
    return b[`HI_MSB:`HI_LSB] == op;
  endfunction

  function automatic logic is_pot_mode(input logic [7:0] b);
    return b == `OP_POT_MODE;
  endfunction

  function automatic logic is_static_ind(input logic [7:0] b);
    return match7(b, `OP_STATIC_IND);
  endfunction

  function automatic logic is_drive_sel(input logic [7:0] b);
    return match_hi(b, `OP_DRIVE_SEL);
  endfunction

  function automatic logic is_display_onoff(input logic [7:0] b);
    return match7(b, `OP_DISP_ONOFF);
  endfunction

  function automatic logic is_all_on(input logic [7:0] b);
    return match7(b, `OP_ALL_ON);
  endfunction

  function automatic logic is_reset(input logic [7:0] b);
    return b == `OP_RESET;
  endfunction

  function automatic logic is_factory_test(input logic [7:0] b);
    return match_hi(b, `OP_TEST);
  endfunction

  // ==========================================
  // opcode decode
  // a pending parameter swallows the byte, even if it looks like an opcode
  assign is_op = cmd.valid && (arg_q == arg_none); // R19

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arg_q <= arg_none;
    end else if (clock_en && cmd.valid) begin
      if (arg_q != arg_none) begin
        arg_q <= arg_none; // R19
      end else if (is_pot_mode(cmd.data)) begin
        arg_q <= arg_pot; // R1
      end else if (is_static_ind(cmd.data)) begin
        arg_q <= arg_blink; // R2
      end else if (is_drive_sel(cmd.data)) begin
        arg_q <= arg_lines; // R4
      end
    end
  end

  // ==========================================
  // parameter registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      top_bias_level <= `POT_RST;
      blink_state    <= `BLINK_RST;
      reversal_lines <= `LINES_RST;
    end else if (clock_en && cmd.valid) begin
      unique case (arg_q)
        arg_pot:   top_bias_level <= cmd.data[`POT_BITS-1:0]; // R1
        arg_blink: blink_state    <= cmd.data[`BLINK_BITS-1:0]; // R2
        arg_lines: reversal_lines <= cmd.data[`LINES_BITS-1:0]; // R4
        arg_none: ;
      endcase
    end
  end

  // ==========================================
  // static indicator; the no-operation byte matches none of these
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      static_ind_on <= 1'b0;
    end else if (clock_en && is_op && is_static_ind(cmd.data)) begin
      static_ind_on <= cmd.data[`ONOFF_BIT]; // R2
    end
  end

  // ==========================================
  // drive method
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      line_reversal <= 1'b0;
    end else if (clock_en && is_op && is_drive_sel(cmd.data)) begin
      line_reversal <= cmd.data[`DRIVE_BIT]; // R3
    end
  end

  // ==========================================
  // display on/off
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      display_on <= 1'b0;
    end else if (clock_en && is_op && is_display_onoff(cmd.data)) begin
      display_on <= cmd.data[`ONOFF_BIT]; // R5
    end
  end

  // ==========================================
  // all-dots-on; also half of the power save pair
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      all_dots_on <= 1'b0;
    end else if (clock_en && is_op && is_all_on(cmd.data)) begin
      all_dots_on <= cmd.data[`ONOFF_BIT]; // R5
    end
  end

  // ==========================================
  // power save
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_state <= pwr_normal;
    end else if (clock_en && is_op) begin
      if (is_all_on(cmd.data)) begin
        if (!cmd.data[`ONOFF_BIT]) begin
          power_state <= pwr_normal; // R16
        end else if (!display_on) begin
          // all-on with the display still lit is only a test pattern
          power_state <= static_ind_on ? pwr_standby : pwr_sleep; // R5 R16
        end
      end else if (is_reset(cmd.data) && power_state == pwr_standby) begin
        // the full internal reset lives outside this block
        power_state <= pwr_sleep; // R17
      end
    end
  end

  // ==========================================
  // factory test
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      test_mode <= 1'b0;
    end else if (clock_en && is_op) begin
      // pin is read at decode, one cycle after capture
      if (is_factory_test(cmd.data)) begin
        test_mode <= factory_test_enable_pin; // R7 R18
      end else if (cmd.data == `OP_NO_OP) begin
        test_mode <= 1'b0; // R6 R18
      end
    end
  end

  // ==========================================
  // output grounding; set with the display-on command so grounding drops with it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      configured_q <= 1'b0;
    end else if (clock_en && is_op && is_display_onoff(cmd.data) && cmd.data[`ONOFF_BIT]) begin
      configured_q <= 1'b1; // R8
    end
  end

  assign drive_outputs_grounded = !configured_q || !display_on || (power_state != pwr_normal); // R8
endmodule

// ---- verif/lcd_decoder_monitor.sv ----
`timescale 1ns/10ps
`include "lcd_cmd_map.svh"
// ==========================================================
// command checker
module lcd_decoder_monitor import lcd_cmd_pkg::*; (
  input wire logic       clock, rst_b, clock_en, write_strobe, command_data_select, factory_test_enable_pin,
  input wire logic [7:0] write_data,
  input wire logic [5:0] top_bias_level,
  input wire logic [1:0] blink_state,
  input wire logic [4:0] reversal_lines,
  input wire logic       static_ind_on, line_reversal, display_on, all_dots_on, test_mode, drive_outputs_grounded,
  input wire pwr_state_t power_state
);
  logic       cmd, op, par, two, arm_q;
  logic [7:0] op_q;
  assign cmd = clock_en && write_strobe && !command_data_select;
  assign op  = cmd && !arm_q;
  assign par = cmd && arm_q;
  assign two = write_data == 8'h81 || write_data[7:1] == 7'h56 || write_data[7:4] == 4'hd;
  // tracks parameter bytes so an opcode-valued parameter is not decoded
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arm_q <= 1'b0;
      op_q  <= 8'h00;
    end else if (cmd) begin
      arm_q <= op && two;
      op_q  <= write_data;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_pot_load: assert property (par && op_q == 8'h81 ##1 clock_en |=> top_bias_level == $past(write_data[5:0], 2))
    else $error("pot level wrong");
  a_ind_set: assert property (op && write_data[7:1] == 7'h56 ##1 clock_en |=> static_ind_on == $past(write_data[0], 2))
    else $error("indicator wrong");
  a_blink_load: assert property (par && op_q[7:1] == 7'h56 ##1 clock_en |=> blink_state == $past(write_data[1:0], 2))
    else $error("blink wrong");
  a_drive_pick: assert property (op && write_data[7:4] == 4'hd ##1 clock_en |=> line_reversal == $past(write_data[3], 2))
    else $error("drive method wrong");
  a_line_count: assert property (par && op_q[7:4] == 4'hd ##1 clock_en |=> reversal_lines == $past(write_data[4:0], 2))
    else $error("line count wrong");
  a_nop_still: assert property (op && write_data == 8'he3 ##1 clock_en |=> $stable(top_bias_level) && !test_mode)
    else $error("nop changed state");
  a_test_gate: assert property (op && write_data[7:4] == 4'hf && !test_mode
    ##1 clock_en && !factory_test_enable_pin |=> !test_mode) else $error("test without pin");
  a_test_enter: assert property (op && write_data[7:4] == 4'hf
    ##1 clock_en && factory_test_enable_pin |=> test_mode) else $error("test not entered");
  a_save_enter: assert property (op && write_data == 8'ha5 ##1 clock_en && !display_on
    |=> power_state == ($past(static_ind_on) ? pwr_standby : pwr_sleep)) else $error("save state wrong");
  a_save_refuse: assert property (op && write_data == 8'ha5
    ##1 clock_en && display_on && power_state == pwr_normal |=> power_state == pwr_normal)
    else $error("save while display on");
  a_reset_sleep: assert property (op && write_data == 8'he2 ##1 clock_en && power_state == pwr_standby
    |=> power_state == pwr_sleep) else $error("standby reset wrong");
  a_freeze_hold: assert property (!clock_en |=> $stable(top_bias_level) && $stable(power_state)
    && $stable(display_on) && $stable(test_mode) && $stable(blink_state)) else $error("state moved while frozen");
  a_ground_out: assert property (!display_on || power_state != pwr_normal |-> drive_outputs_grounded)
    else $error("outputs not grounded");
  c_standby: cover property (power_state == pwr_standby);
  c_test: cover property (test_mode);
  c_param: cover property (par && two);
endmodule
bind lcd_cmd_tail_decoder lcd_decoder_monitor u_mon (.*);

// ---- verif/host_mcu_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// host controller writing bytes
module host_mcu_model (
  input  wire logic  clock,
  output logic       write_strobe = 1'b0,
  output logic       command_data_select = 1'b1,
  output logic [7:0] write_data = 8'h00
);
  // idle bus shows the inverted byte so stale data never passes as fresh
  task automatic put(logic sel, logic [7:0] b);
    @(posedge clock);
    write_strobe <= 1'b1;
    command_data_select <= sel;
    write_data <= b;
    @(posedge clock);
    write_strobe <= 1'b0;
    command_data_select <= ~sel;
    write_data <= ~b;
  endtask
endmodule

// ---- verif/lcd_cmd_tail_decoder_bench.sv ----
`timescale 1ns/10ps
`include "lcd_cmd_map.svh"
// ==========================================================
// command sequences against expected settings
module lcd_cmd_tail_decoder_bench import lcd_cmd_pkg::*;;
  logic                   clock = 1'b0, rst_b = 1'b0, clock_en = 1'b1, factory_test_enable_pin = 1'b0;
  logic                   write_strobe, command_data_select, static_ind_on, line_reversal;
  logic                   display_on, all_dots_on, test_mode, drive_outputs_grounded;
  logic [7:0]             write_data;
  logic [`POT_BITS-1:0]   top_bias_level;
  logic [`BLINK_BITS-1:0] blink_state;
  logic [`LINES_BITS-1:0] reversal_lines;
  pwr_state_t             power_state;
  int                     err_count = 0, checked = 0, cycles = 0;
  always #2 clock = ~clock;
  host_mcu_model host (.*);
  lcd_cmd_tail_decoder dut (.*);
  task automatic end_of_test;
    $display("checked %0d wrong %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_of_test;
    end
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // effect lands one edge after capture
  task automatic cmd(logic [7:0] b);
    host.put(1'b0, b);
    @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk("grounded", 8'h01, 8'(drive_outputs_grounded));
    cmd(8'hae);
    cmd(8'ha5);
    chk("state", pwr_sleep, 8'(power_state));
    chk("all on", 8'h01, 8'(all_dots_on));
    cmd(8'ha4);
    chk("state", pwr_normal, 8'(power_state));
    cmd(8'h2f);
    chk("display", 8'h00, 8'(display_on));
    $display("test power-on done");
    cmd(8'h81);
    cmd(8'hff);
    chk("pot", 8'h3f, 8'(top_bias_level));
    cmd(8'h81);
    cmd(8'haf);
    chk("pot", 8'h2f, 8'(top_bias_level));
    chk("display", 8'h00, 8'(display_on));
    host.put(1'b1, 8'h81);
    cmd(8'h05);
    chk("pot", 8'h2f, 8'(top_bias_level));
    $display("test pot done");
    repeat (2) begin
      cmd(8'had);
      cmd(8'hfe);
      chk("indicator", 8'h01, 8'(static_ind_on));
      chk("blink", 8'h02, 8'(blink_state));
      cmd(8'hd8);
      cmd(8'he3);
      chk("line rev", 8'h01, 8'(line_reversal));
      chk("lines", 8'h03, 8'(reversal_lines));
      cmd(8'hd7);
      cmd(8'hff);
      chk("line rev", 8'h00, 8'(line_reversal));
      chk("lines", 8'h1f, 8'(reversal_lines));
      cmd(8'he3);
      chk("lines", 8'h1f, 8'(reversal_lines));
      chk("blink", 8'h02, 8'(blink_state));
    end
    $display("test settings done");
    cmd(8'haf);
    chk("grounded", 8'h00, 8'(drive_outputs_grounded));
    cmd(8'ha5);
    chk("state", pwr_normal, 8'(power_state));
    chk("all on", 8'h01, 8'(all_dots_on));
    cmd(8'hae);
    cmd(8'ha5);
    chk("state", pwr_standby, 8'(power_state));
    chk("grounded", 8'h01, 8'(drive_outputs_grounded));
    cmd(8'he2);
    chk("state", pwr_sleep, 8'(power_state));
    cmd(8'ha4);
    chk("state", pwr_normal, 8'(power_state));
    chk("all on", 8'h00, 8'(all_dots_on));
    $display("test power done");
    cmd(8'hf5);
    chk("test", 8'h00, 8'(test_mode));
    @(posedge clock);
    factory_test_enable_pin <= 1'b1;
    cmd(8'hf0);
    chk("test", 8'h01, 8'(test_mode));
    cmd(8'he3);
    chk("test", 8'h00, 8'(test_mode));
    $display("test factory done");
    @(posedge clock);
    clock_en <= 1'b0;
    cmd(8'haf);
    chk("display", 8'h00, 8'(display_on));
    chk("grounded", 8'h01, 8'(drive_outputs_grounded));
    @(posedge clock);
    clock_en <= 1'b1;
    $display("test freeze done");
    cmd(8'hae);
    cmd(8'ha5);
    chk("state", pwr_standby, 8'(power_state));
    chk("grounded", 8'h01, 8'(drive_outputs_grounded));
    $display("test power-off done");
    end_of_test;
  end
endmodule
